// ===== hw/atss_sequencer.sv
// Touch screen converter sequencer top module
// Overview of operation
// - Auto and axis both zero: plain conversion into x result field.
// - Axis one: convert X, store x result, then pulse done interrupt.
// - Axis two: convert Y, store y result, then pulse done interrupt.
// - X drives x-plus, grounds x-minus, senses ch5; Y mirrors on ch7.
// - Auto X phase uses the same pad setup as separate X.
// - Auto set, axis zero: convert X then Y without further requests.
// - Auto stores X then Y, one done interrupt after both.
// - Each result is a 10-bit code of the selected input.
// - Converter clock at most 2.5 MHz; software picks the prescale.
// - Converter clock is system clock over prescale plus one; five cycles.
// - Drive four panel transistor controls and pick channels 7 and 5.
// - Pull-up on channel 7 for stylus contact detection.
// - Eight selectable analog input channels.
// - Prescale field sits in bits 13 to 6 of the control word.
// - End flag bit 15 reads 0 while busy, 1 when done.
// - In wait mode, stylus press raises the touch interrupt.
// - Standby halts conversion and keeps both result fields.
`timescale 1ns/10ps
`default_nettype none
module atss_sequencer #(
    parameter int RES_W = atss_pkg::RES_W,
    parameter int PRE_W = atss_pkg::PRE_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Software control
    input wire logic start_i,
    input wire logic auto_sequence_select_i,
    input wire logic [1:0] manual_axis_select_i,
    input wire logic [atss_pkg::CH_W-1:0] channel_select_i,
    input wire logic [PRE_W-1:0] prescale_value_i,
    input wire logic standby_select_i,
    input wire logic pullup_disable_i,
    // Converter core
    input wire logic [RES_W-1:0] sample_i,
    input wire logic stylus_down_i,
    // Converter and panel outputs
    output logic [atss_pkg::CH_W-1:0] analog_input_sel_o,
    output var atss_pkg::atss_panel_t panel_o,
    // Status and results
    output logic [15:0] converter_control_word_o,
    output var atss_pkg::atss_result_t result_o,
    output logic conv_done_irq_o,
    output logic stylus_touch_irq_o
);
    typedef enum logic [1:0] {
        ATSS_IDLE,
        ATSS_CONV_X,
        ATSS_CONV_Y
    } atss_state_t;

    atss_state_t state_reg;
    logic [2:0] cyc_reg;
    logic done_flag_reg;
    logic auto_reg;
    logic [1:0] axis_reg;
    logic [atss_pkg::CH_W-1:0] ch_reg;
    logic [RES_W-1:0] x_reg;
    logic [RES_W-1:0] y_reg;
    logic done_irq_reg;
    logic touch_irq_reg;
    logic stylus_prev_reg;
    logic tick;
    logic conv_end;
    logic busy;

    assign busy = (state_reg != ATSS_IDLE);

    // clock limit is software choice; prescale below minimum is out of spec
    atss_conv_clk #(
        .PRE_W(PRE_W)
    ) u_clk (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(busy && !standby_select_i),
        .prescale_value_i(prescale_value_i),
        .tick_o(tick)
    );

    assign conv_end = tick && (cyc_reg == 3'(atss_pkg::CONV_CYCLES - 1));

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    // start ignored while busy
    // standby blocks new starts and freezes progress
    // auto runs Y after X without new request
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ATSS_IDLE;
            auto_reg <= 1'b0;
            axis_reg <= atss_pkg::AXIS_NONE;
            ch_reg <= '0;
        end else begin
            case (state_reg)
                ATSS_IDLE: begin
                    if (start_i && !standby_select_i && manual_axis_select_i != atss_pkg::AXIS_WAIT) begin
                        auto_reg <= auto_sequence_select_i;
                        axis_reg <= manual_axis_select_i;
                        ch_reg <= channel_select_i;
                        if (!auto_sequence_select_i && manual_axis_select_i == atss_pkg::AXIS_Y) begin
                            state_reg <= ATSS_CONV_Y;
                        end else begin
                            state_reg <= ATSS_CONV_X;
                        end
                    end
                end
                ATSS_CONV_X: begin
                    if (conv_end) begin
                        state_reg <= auto_reg ? ATSS_CONV_Y : ATSS_IDLE;
                    end
                end
                ATSS_CONV_Y: begin
                    if (conv_end) begin
                        state_reg <= ATSS_IDLE;
                    end
                end
                default: begin
                    state_reg <= ATSS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Converter cycle count
    // ------------------------------------------------------------
    // five converter cycles per conversion
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !busy) begin
            cyc_reg <= '0;
        end else if (conv_end) begin
            cyc_reg <= '0;
        end else if (tick) begin
            cyc_reg <= cyc_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------
    // plain conversion lands in x result field
    // X then Y into separate words
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            x_reg <= atss_pkg::RESULT_RESET;
            y_reg <= atss_pkg::RESULT_RESET;
        end else if (conv_end) begin
            if (state_reg == ATSS_CONV_Y) begin
                y_reg <= sample_i;
            end else begin
                x_reg <= sample_i;
            end
        end
    end

    // ------------------------------------------------------------
    // End flag and done interrupt
    // ------------------------------------------------------------
    // end flag clears at start, sets at completion
    // one pulse only after both in auto
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_flag_reg <= 1'b0;
            done_irq_reg <= 1'b0;
        end else begin
            done_irq_reg <= conv_end && !(state_reg == ATSS_CONV_X && auto_reg);
            if (conv_end && !(state_reg == ATSS_CONV_X && auto_reg)) begin
                done_flag_reg <= 1'b1;
            end else if (!busy && start_i && !standby_select_i && manual_axis_select_i != atss_pkg::AXIS_WAIT) begin
                done_flag_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Stylus touch interrupt
    // ------------------------------------------------------------
    // touch pulse on press in wait mode
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stylus_prev_reg <= 1'b0;
            touch_irq_reg <= 1'b0;
        end else begin
            stylus_prev_reg <= stylus_down_i;
            touch_irq_reg <= !busy && manual_axis_select_i == atss_pkg::AXIS_WAIT
                && stylus_down_i && !stylus_prev_reg;
        end
    end

    // ------------------------------------------------------------
    // Panel and channel drive
    // ------------------------------------------------------------
    // X and Y pad setups
    // auto X phase same as separate X
    // four transistor controls and sense channels
    // pull-up on channel 7 when waiting
    // any of eight channels for plain conversion
    always_comb begin
        panel_o.y_plus_drive_n = 1'b1;
        panel_o.y_minus_ground = 1'b0;
        panel_o.x_plus_drive_n = 1'b1;
        panel_o.x_minus_ground = 1'b0;
        panel_o.x_plus_pullup = 1'b0;
        analog_input_sel_o = ch_reg;
        if (state_reg == ATSS_CONV_X && (auto_reg || axis_reg == atss_pkg::AXIS_X)) begin
            panel_o.x_plus_drive_n = 1'b0;
            panel_o.x_minus_ground = 1'b1;
            analog_input_sel_o = atss_pkg::CH_X_SENSE;
        end else if (state_reg == ATSS_CONV_Y) begin
            panel_o.y_plus_drive_n = 1'b0;
            panel_o.y_minus_ground = 1'b1;
            analog_input_sel_o = atss_pkg::CH_Y_SENSE;
        end else if (!busy && manual_axis_select_i == atss_pkg::AXIS_WAIT) begin
            panel_o.y_minus_ground = 1'b1;
            panel_o.x_plus_pullup = !pullup_disable_i;
        end
    end

    // prescale in bits 13..6, flag in bit 15
    always_comb begin
        converter_control_word_o = '0;
        converter_control_word_o[atss_pkg::CTRL_FLAG_BIT] = done_flag_reg;
        converter_control_word_o[atss_pkg::CTRL_PRE_HI:atss_pkg::CTRL_PRE_LO] = prescale_value_i;
        converter_control_word_o[atss_pkg::CTRL_STBY_BIT] = standby_select_i;
    end

    assign result_o.x_result_field = x_reg;
    assign result_o.y_result_field = y_reg;
    assign conv_done_irq_o = done_irq_reg;
    assign stylus_touch_irq_o = touch_irq_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    x_pads_set_a: assert property (state_reg == ATSS_CONV_X && auto_reg |->
        !panel_o.x_plus_drive_n && panel_o.x_minus_ground && analog_input_sel_o == atss_pkg::CH_X_SENSE)
        else $error("auto X pads wrong");
    y_pads_set_a: assert property (state_reg == ATSS_CONV_Y |->
        !panel_o.y_plus_drive_n && panel_o.y_minus_ground && panel_o.x_plus_drive_n
        && analog_input_sel_o == atss_pkg::CH_Y_SENSE)
        else $error("Y pads wrong");
    auto_no_mid_irq_a: assert property (conv_end && state_reg == ATSS_CONV_X && auto_reg |=>
        !conv_done_irq_o && state_reg == ATSS_CONV_Y)
        else $error("auto irq after X");
    x_store_a: assert property (conv_end && state_reg == ATSS_CONV_X |=>
        result_o.x_result_field == $past(sample_i) && conv_done_irq_o == !$past(auto_reg))
        else $error("X result not stored");
    y_store_a: assert property (conv_end && state_reg == ATSS_CONV_Y |=>
        result_o.y_result_field == $past(sample_i) && conv_done_irq_o)
        else $error("Y result not stored");
    flag_busy_a: assert property (busy |->
        !converter_control_word_o[atss_pkg::CTRL_FLAG_BIT])
        else $error("end flag set while busy");
    flag_on_done_a: assert property (conv_done_irq_o |->
        converter_control_word_o[atss_pkg::CTRL_FLAG_BIT])
        else $error("end flag missing at done");
    standby_hold_a: assert property (standby_select_i && !busy |=>
        $stable(result_o) && !busy)
        else $error("standby not holding");
    busy_ignore_a: assert property (busy && start_i && !conv_end |=>
        $stable(auto_reg) && $stable(axis_reg))
        else $error("request taken while busy");
    touch_irq_a: assert property (!busy && manual_axis_select_i == atss_pkg::AXIS_WAIT
        && stylus_down_i && !stylus_prev_reg |=> stylus_touch_irq_o)
        else $error("touch irq missing");
    prescale_field_a: assert property (
        converter_control_word_o[atss_pkg::CTRL_PRE_HI:atss_pkg::CTRL_PRE_LO] == prescale_value_i)
        else $error("prescale field wrong");
    normal_pads_a: assert property (state_reg == ATSS_CONV_X && !auto_reg && axis_reg == atss_pkg::AXIS_NONE |->
        panel_o.x_plus_drive_n && panel_o.y_plus_drive_n && analog_input_sel_o == ch_reg)
        else $error("normal conversion pads wrong");
    sep_x_pads_a: assert property (state_reg == ATSS_CONV_X && axis_reg == atss_pkg::AXIS_X |->
        !panel_o.x_plus_drive_n && panel_o.x_minus_ground && panel_o.y_plus_drive_n && !panel_o.y_minus_ground)
        else $error("separate X pads wrong");
    wait_pads_a: assert property (!busy && manual_axis_select_i == atss_pkg::AXIS_WAIT |->
        panel_o.y_minus_ground && panel_o.y_plus_drive_n && panel_o.x_plus_drive_n && !panel_o.x_minus_ground
        && panel_o.x_plus_pullup == !pullup_disable_i)
        else $error("wait pads wrong");
    idle_release_a: assert property (!busy && manual_axis_select_i != atss_pkg::AXIS_WAIT |->
        panel_o.y_plus_drive_n && !panel_o.y_minus_ground && panel_o.x_plus_drive_n && !panel_o.x_minus_ground
        && !panel_o.x_plus_pullup)
        else $error("idle pads not released");
    done_one_cycle_a: assert property (conv_done_irq_o |=>
        !conv_done_irq_o)
        else $error("done pulse too long");


    auto_seq_c: cover property (conv_done_irq_o && auto_reg);
    sep_y_c: cover property (conv_done_irq_o && axis_reg == atss_pkg::AXIS_Y && !auto_reg);
    touch_c: cover property (stylus_touch_irq_o);
    sep_x_c: cover property (conv_done_irq_o && axis_reg == atss_pkg::AXIS_X && !auto_reg);
    normal_c: cover property (conv_done_irq_o && axis_reg == atss_pkg::AXIS_NONE && !auto_reg);
endmodule : atss_sequencer
`default_nettype wire

// ===== hw/atss_pkg.sv
// Package with constants and types for the touch screen converter sequencer
package atss_pkg;
    // ------------------------------------------------------------
    // Field widths and channels
    // ------------------------------------------------------------
    localparam int RES_W = 10;
    localparam int CH_W = 3;
    localparam int PRE_W = 8;
    localparam logic [2:0] CH_X_SENSE = 3'h5;
    localparam logic [2:0] CH_Y_SENSE = 3'h7;
    localparam logic [1:0] AXIS_NONE = 2'h0;
    localparam logic [1:0] AXIS_X = 2'h1;
    localparam logic [1:0] AXIS_Y = 2'h2;
    localparam logic [1:0] AXIS_WAIT = 2'h3;
    // ------------------------------------------------------------
    // Control word layout and reset values
    // ------------------------------------------------------------
    localparam int CTRL_FLAG_BIT = 15;
    localparam int CTRL_PRE_HI = 13;
    localparam int CTRL_PRE_LO = 6;
    localparam int CTRL_STBY_BIT = 2;
    localparam logic [7:0] PRE_RESET = 8'hFF;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CONV_CYCLES = 5;
    localparam real CONV_CLK_MAX_MHZ = 2.5;
    localparam real SYS_CLK_MHZ = 10.0;
    // Smallest legal prescale value for the converter clock limit
    localparam int PRE_MIN = $rtoi(SYS_CLK_MHZ / CONV_CLK_MAX_MHZ + 0.999) - 1;

    // Panel transistor controls
    typedef struct packed {
        logic y_plus_drive_n;
        logic y_minus_ground;
        logic x_plus_drive_n;
        logic x_minus_ground;
        logic x_plus_pullup;
    } atss_panel_t;

    // Result words
    typedef struct packed {
        logic [9:0] x_result_field;
        logic [9:0] y_result_field;
    } atss_result_t;
endpackage : atss_pkg

// ===== hw/atss_conv_clk.sv
// Converter clock prescaler producing one enable pulse per converter clock
`timescale 1ns/10ps
`default_nettype none
module atss_conv_clk #(
    parameter int PRE_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic run_i,
    input wire logic [PRE_W-1:0] prescale_value_i,
    // Tick
    output logic tick_o
);
    logic [PRE_W-1:0] cnt_reg;

    // ------------------------------------------------------------
    // Divide by value plus one
    // ------------------------------------------------------------
    // divide by N+1
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !run_i) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= prescale_value_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick_o = run_i && (cnt_reg >= prescale_value_i);
endmodule : atss_conv_clk
`default_nettype wire

// ===== testbench/atss_panel_model.sv
// Resistive touch panel model seen through four external transistors
`timescale 1ns/10ps
`default_nettype none
module atss_panel_model (
    // Clock
    input wire logic clk_i,
    // Panel controls
    input wire atss_pkg::atss_panel_t panel_i,
    input wire logic [2:0] analog_input_sel_i,
    // Stimulus
    input wire logic touch_i,
    input wire logic [9:0] x_pos_i,
    input wire logic [9:0] y_pos_i,
    // Converter side
    output logic [9:0] sample_o,
    output logic stylus_down_o
);
    logic [9:0] junk_reg = 10'h2AA;

    // Wrong pad setup reads a pattern changing every cycle
    always_ff @(posedge clk_i) begin
        junk_reg <= ~junk_reg ^ 10'h155;
    end

    // position only with the right pads and channel
    always_comb begin
        if (panel_i[4:1] == 4'h9 && analog_input_sel_i == 3'h5) begin
            sample_o = x_pos_i;
        end else if (panel_i[4:1] == 4'h6 && analog_input_sel_i == 3'h7) begin
            sample_o = y_pos_i;
        end else if (panel_i[4:1] == 4'hA) begin
            sample_o = {analog_input_sel_i, 7'h35};
        end else begin
            sample_o = junk_reg;
        end
    end

    // contact seen only with pull-up and grounded y-minus
    assign stylus_down_o = touch_i & panel_i.x_plus_pullup & panel_i.y_minus_ground;
endmodule : atss_panel_model
`default_nettype wire

// ===== testbench/atss_sequencer_tb.sv
// Testbench for the touch screen converter sequencer
`timescale 1ns/10ps
`default_nettype none
module atss_sequencer_tb;
    localparam int PCLK_NS = 100;
    localparam logic [9:0] Y_FIRST = 10'h13A;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic start_i = 1'b0;
    logic auto_sequence_select_i = 1'b0;
    logic [1:0] manual_axis_select_i = 2'h0;
    logic [2:0] channel_select_i = 3'h0;
    logic [7:0] prescale_value_i = 8'h03;
    logic standby_select_i = 1'b0;
    logic pullup_disable_i = 1'b0;
    logic touch = 1'b0;
    logic [9:0] x_pos = 10'h2C7;
    logic [9:0] y_pos = Y_FIRST;
    logic [9:0] y_prev = Y_FIRST;
    logic [9:0] sample_i;
    logic stylus_down_i;
    logic [2:0] analog_input_sel_o;
    atss_pkg::atss_panel_t panel_o;
    logic [15:0] converter_control_word_o;
    atss_pkg::atss_result_t result_o;
    logic conv_done_irq_o;
    logic stylus_touch_irq_o;
    int err_count = 0;
    int n_compared = 0;
    int n_touch = 0;
    int n_done = 0;

    atss_sequencer atss_sequencer_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
        .auto_sequence_select_i(auto_sequence_select_i), .manual_axis_select_i(manual_axis_select_i),
        .channel_select_i(channel_select_i), .prescale_value_i(prescale_value_i),
        .standby_select_i(standby_select_i), .pullup_disable_i(pullup_disable_i), .sample_i(sample_i),
        .stylus_down_i(stylus_down_i), .analog_input_sel_o(analog_input_sel_o), .panel_o(panel_o),
        .converter_control_word_o(converter_control_word_o), .result_o(result_o),
        .conv_done_irq_o(conv_done_irq_o), .stylus_touch_irq_o(stylus_touch_irq_o));

    atss_panel_model atss_panel_model_i (.clk_i(clk_i), .panel_i(panel_o),
        .analog_input_sel_i(analog_input_sel_o), .touch_i(touch), .x_pos_i(x_pos), .y_pos_i(y_pos),
        .sample_o(sample_i), .stylus_down_o(stylus_down_i));

    initial begin
        forever #(PCLK_NS / 2) clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (stylus_touch_irq_o === 1'b1) n_touch++;
        if (conv_done_irq_o === 1'b1) n_done++;
    end

    // ------------------------------------------------------------
    // Check and access tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic convert(input logic auto_sel, input logic [1:0] axis, input logic [2:0] ch,
            input logic [3:0] pads, input int cyc);
        int n;
        @(posedge clk_i) auto_sequence_select_i <= auto_sel;
        manual_axis_select_i <= axis;
        channel_select_i <= ch;
        @(posedge clk_i) start_i <= 1'b1;
        @(posedge clk_i) start_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n == 3) start_i <= 1'b1;
            if (n == 4) start_i <= 1'b0;
            #1;
            if (n == 2) begin
                chk("busy flag", 16'h0, {15'h0, converter_control_word_o[15]});
                if (pads != 4'h0) chk("pads", {12'h0, pads}, {12'h0, panel_o[4:1]});
                chk("channel", {13'h0, (pads == 4'h9) ? 3'h5 : (pads == 4'h6) ? 3'h7 : ch},
                    {13'h0, analog_input_sel_o});
            end
            if (auto_sel && n == cyc / 2 + 1) begin
                chk("auto x first", {6'h0, x_pos}, {6'h0, result_o.x_result_field});
                chk("auto y later", {6'h0, y_prev}, {6'h0, result_o.y_result_field});
            end
        end while (conv_done_irq_o !== 1'b1 && n < 3000);
        chk("latency", cyc[15:0], n[15:0]);
        @(posedge clk_i);
        #1;
        chk("done pulse", 16'h0, {15'h0, conv_done_irq_o});
        @(posedge clk_i);
        #1;
        chk("end flag", 16'h1, {15'h0, converter_control_word_o[15]});
        chk("pads idle", 16'hA, {12'h0, panel_o[4:1]});
    endtask : convert

    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #(PCLK_NS * 20000);
        err_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        int d;
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("reset ctrl", 16'h00C0, converter_control_word_o);
        chk("reset x", 16'h0, {6'h0, result_o.x_result_field});
        for (d = atss_pkg::PRE_MIN; d <= atss_pkg::PRE_MIN + 1; d++) begin
            @(posedge clk_i) prescale_value_i <= d[7:0];
            x_pos <= 10'h2C7;
            y_pos <= Y_FIRST;
            @(posedge clk_i);
            #1;
            chk("ctrl word", {d > atss_pkg::PRE_MIN, 1'b0, d[7:0], 6'h0}, converter_control_word_o);
            for (int c = 0; c < 8; c++) begin
                convert(1'b0, 2'h0, c[2:0], 4'hA, 5 * (d + 1));
                chk("normal", {6'h0, c[2:0], 7'h35}, {6'h0, result_o.x_result_field});
            end
            convert(1'b0, 2'h1, 3'h0, 4'h9, 5 * (d + 1));
            chk("x sep", {6'h0, x_pos}, {6'h0, result_o.x_result_field});
            convert(1'b0, 2'h2, 3'h0, 4'h6, 5 * (d + 1));
            chk("y sep", {6'h0, Y_FIRST}, {6'h0, result_o.y_result_field});
            x_pos <= 10'h0F3;
            y_pos <= 10'h3FF;
            convert(1'b1, 2'h0, 3'h0, 4'h9, 10 * (d + 1));
            chk("auto y", 16'h03FF, {6'h0, result_o.y_result_field});
        end
        // standby blocks starts and keeps results
        @(posedge clk_i) standby_select_i <= 1'b1;
        d = n_done;
        @(posedge clk_i) start_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        start_i <= 1'b0;
        #1;
        chk("standby bit", 16'h1, {15'h0, converter_control_word_o[2]});
        chk("standby irq", d[15:0], n_done[15:0]);
        chk("standby x", 16'h00F3, {6'h0, result_o.x_result_field});
        @(posedge clk_i) standby_select_i <= 1'b0;
        manual_axis_select_i <= 2'h3;
        pullup_disable_i <= 1'b1;
        touch <= 1'b1;
        start_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        #1;
        chk("no touch", 16'h0, n_touch[15:0]);
        chk("wait refuses", d[15:0], n_done[15:0]);
        @(posedge clk_i) start_i <= 1'b0;
        touch <= 1'b0;
        pullup_disable_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("wait pads", 16'h1D, {11'h0, panel_o});
        @(posedge clk_i) touch <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("touch irq", 16'h1, n_touch[15:0]);
        // touch, convert, then back to waiting
        y_prev = 10'h3FF;
        convert(1'b1, 2'h0, 3'h0, 4'h9, 10 * (atss_pkg::PRE_MIN + 2));
        @(posedge clk_i) manual_axis_select_i <= 2'h3;
        repeat (3) @(posedge clk_i);
        #1;
        chk("rewait pads", 16'h1D, {11'h0, panel_o});
        give_verdict();
    end
endmodule : atss_sequencer_tb
`default_nettype wire
